// ===== sbd_dio_port.sv
/*
  Sixteen channel digital I/O port with byte-wise direction control.
  Assumes synchronous pin inputs and a master that never overlaps strobes.
*/
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sbd_dio_port
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire logic [sbd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sbd_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sbd_pkg::DATA_W-1:0] reg_rdata,
  // Channel pins
  input wire logic [sbd_pkg::DATA_W-1:0] dio_in,
  output logic [sbd_pkg::DATA_W-1:0] dio_out,
  output logic [sbd_pkg::DATA_W-1:0] dio_oe
);
  import sbd_pkg::*;

  // Byte groups in the port; the loop below builds one lane per group
  localparam int unsigned BYTE_COUNT = DATA_W / BYTE_W;
  // Only the two direction fields read back, every other bit is zero
  localparam logic [DATA_W-1:0] CFG_READ_MASK =
    (DATA_W'(1'b1) << POS_HIGH_DIR) | (DATA_W'(1'b1) << POS_LOW_DIR);

  typedef struct packed {
    logic [DATA_W-1:0] output_latch_bits;
    logic high_byte_direction;
    logic low_byte_direction;
    logic [DATA_W-1:0] rdata;
  } sbd_state_type;

  sbd_state_type state_reg;
  sbd_state_type state_next;
  logic [DATA_W-1:0] input_sample_bits;
  logic [BYTE_COUNT-1:0] byte_is_in;
  // Decoded strobes; offsets outside the map hit nothing
  logic wr_data_hit;
  logic wr_cfg_hit;
  logic rd_data_hit;
  logic rd_cfg_hit;
  logic [DATA_W-1:0] cfg_read_word;

  ////////////////////////////////////////////////////////////////////////
  // Per-byte pin drive and read-back selection
  assign byte_is_in = {state_reg.high_byte_direction, state_reg.low_byte_direction};
  genvar g;
  generate
    for (g = 0; g < BYTE_COUNT; g++)
    begin : g_byte
      assign dio_oe[g*BYTE_W +: BYTE_W] = {BYTE_W{~byte_is_in[g]}};
      assign dio_out[g*BYTE_W +: BYTE_W] = byte_is_in[g] ? ZERO_WORD[BYTE_W-1:0]
                                          : state_reg.output_latch_bits[g*BYTE_W +: BYTE_W];
      // output byte reads back driven value
      assign input_sample_bits[g*BYTE_W +: BYTE_W] = byte_is_in[g] ? dio_in[g*BYTE_W +: BYTE_W]
                                          : state_reg.output_latch_bits[g*BYTE_W +: BYTE_W];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Address decode; the master never raises both strobes at once
  assign wr_data_hit = reg_wr && (reg_addr == OFS_DIO_DATA);
  assign wr_cfg_hit = reg_wr && (reg_addr == OFS_DIO_CFG);
  assign rd_data_hit = reg_rd && (reg_addr == OFS_DIO_DATA);
  assign rd_cfg_hit = reg_rd && (reg_addr == OFS_DIO_CFG);

  always_comb
  begin
    cfg_read_word = ZERO_WORD;
    cfg_read_word[POS_HIGH_DIR] = state_reg.high_byte_direction;
    cfg_read_word[POS_LOW_DIR] = state_reg.low_byte_direction;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state: register writes and read data
  always_comb
  begin
    state_next = state_reg;
    // Read data is a one-cycle pulse while clk_en stays high, zero unless a read was taken
    state_next.rdata = ZERO_WORD;
    if (wr_data_hit)
    begin
      state_next.output_latch_bits = reg_wdata;
    end
    if (wr_cfg_hit)
    begin
      state_next.high_byte_direction = reg_wdata[POS_HIGH_DIR];
      state_next.low_byte_direction = reg_wdata[POS_LOW_DIR];
    end
    if (rd_data_hit)
    begin
      state_next.rdata = input_sample_bits;
    end
    else if (rd_cfg_hit)
    begin
      state_next.rdata = cfg_read_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; clock enable freezes everything but reset, which loads even with clk_en low
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg.output_latch_bits <= RST_OUT_DATA;
      state_reg.high_byte_direction <= RST_DIR;
      state_reg.low_byte_direction <= RST_DIR;
      state_reg.rdata <= ZERO_WORD;
    end
    else if (clk_en)
      state_reg <= state_next;
  end

  // Read data stands in the cycle after the strobe, and holds longer while clk_en is low
  assign reg_rdata = state_reg.rdata;

  ////////////////////////////////////////////////////////////////////////
  // Assertions; quiet while reset is high

  a_input_no_drive: assert property (@(posedge clk) disable iff (rst)
    state_reg.low_byte_direction |-> dio_oe[BYTE_W-1:0] == ZERO_WORD[BYTE_W-1:0])
    else $error("input low byte drives pins");

  a_high_no_drive: assert property (@(posedge clk) disable iff (rst)
    state_reg.high_byte_direction |-> dio_oe[DATA_W-1:BYTE_W] == ZERO_WORD[BYTE_W-1:0])
    else $error("input high byte drives pins");

  a_input_out_zero: assert property (@(posedge clk) disable iff (rst)
    (dio_out & ~dio_oe) == ZERO_WORD)
    else $error("undriven line shows data");

  a_out_drive: assert property (@(posedge clk) disable iff (rst)
    (dio_out & dio_oe) == (state_reg.output_latch_bits & dio_oe))
    else $error("output byte drives wrong level");

  a_high_dir_oe: assert property (@(posedge clk) disable iff (rst)
    dio_oe[DATA_W-1:BYTE_W] == {BYTE_W{~state_reg.high_byte_direction}})
    else $error("high byte enable mismatch");

  a_low_dir_oe: assert property (@(posedge clk) disable iff (rst)
    dio_oe[BYTE_W-1:0] == {BYTE_W{~state_reg.low_byte_direction}})
    else $error("low byte enable mismatch");

  a_data_write: assert property (@(posedge clk) disable iff (rst)
    (clk_en && wr_data_hit && !state_reg.low_byte_direction)
    |=> dio_out[BYTE_W-1:0] == $past(reg_wdata[BYTE_W-1:0]))
    else $error("written output not driven");

  a_data_write_hi: assert property (@(posedge clk) disable iff (rst)
    (clk_en && wr_data_hit && !state_reg.high_byte_direction)
    |=> dio_out[DATA_W-1:BYTE_W] == $past(reg_wdata[DATA_W-1:BYTE_W]))
    else $error("written high byte not driven");

  a_cfg_write: assert property (@(posedge clk) disable iff (rst)
    (clk_en && wr_cfg_hit)
    |=> state_reg.high_byte_direction == $past(reg_wdata[POS_HIGH_DIR])
    && state_reg.low_byte_direction == $past(reg_wdata[POS_LOW_DIR]))
    else $error("direction write not taken");

  a_cfg_readback: assert property (@(posedge clk) disable iff (rst)
    (clk_en && wr_cfg_hit) ##1 (clk_en && rd_cfg_hit)
    |=> reg_rdata == ($past(reg_wdata, 2) & CFG_READ_MASK))
    else $error("config read back wrong");

  // Unmapped write ignored
  a_unmapped_write: assert property (@(posedge clk) disable iff (rst)
    (clk_en && reg_wr && !wr_data_hit && !wr_cfg_hit)
    |=> state_reg.output_latch_bits == $past(state_reg.output_latch_bits)
    && dio_oe == $past(dio_oe))
    else $error("unmapped write changed state");

  // Unmapped read zero
  a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
    (clk_en && reg_rd && !rd_data_hit && !rd_cfg_hit) |=> reg_rdata == ZERO_WORD)
    else $error("unmapped read not zero");

  a_data_readin: assert property (@(posedge clk) disable iff (rst)
    (clk_en && rd_data_hit && state_reg.low_byte_direction
     && state_reg.high_byte_direction) |=> reg_rdata == $past(dio_in))
    else $error("input levels not returned");

  a_out_readback: assert property (@(posedge clk) disable iff (rst)
    (clk_en && rd_data_hit && !state_reg.low_byte_direction
     && !state_reg.high_byte_direction) |=> reg_rdata == $past(state_reg.output_latch_bits))
    else $error("driven level not read back");

  a_mixed_readback: assert property (@(posedge clk) disable iff (rst)
    (clk_en && rd_data_hit && !state_reg.low_byte_direction
     && state_reg.high_byte_direction)
    |=> reg_rdata == {$past(dio_in[DATA_W-1:BYTE_W]),
                      $past(state_reg.output_latch_bits[BYTE_W-1:0])})
    else $error("low driven byte not read back");

  a_mixed_hi_readback: assert property (@(posedge clk) disable iff (rst)
    (clk_en && rd_data_hit && state_reg.low_byte_direction
     && !state_reg.high_byte_direction)
    |=> reg_rdata == {$past(state_reg.output_latch_bits[DATA_W-1:BYTE_W]),
                      $past(dio_in[BYTE_W-1:0])})
    else $error("high driven byte not read back");

  a_byte_uniform: assert property (@(posedge clk) disable iff (rst)
    dio_oe[BYTE_W-1:0] == {BYTE_W{dio_oe[0]}}
    && dio_oe[DATA_W-1:BYTE_W] == {BYTE_W{dio_oe[BYTE_W]}})
    else $error("byte direction not uniform");

  // Read data one pulse
  a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !reg_rd) |=> reg_rdata == ZERO_WORD)
    else $error("read data outside read cycle");

  // Clock enable freeze, read data included
  a_freeze_hold: assert property (@(posedge clk) disable iff (rst)
    !clk_en |=> state_reg == $past(state_reg))
    else $error("state moved while frozen");

  // Main scenarios reached
  c_mixed_dir: cover property (@(posedge clk) disable iff (rst)
    state_reg.high_byte_direction && !state_reg.low_byte_direction);
  c_all_out: cover property (@(posedge clk) disable iff (rst)
    !state_reg.high_byte_direction && !state_reg.low_byte_direction && reg_rd);
  c_wr_then_rd: cover property (@(posedge clk) disable iff (rst)
    wr_data_hit ##1 rd_data_hit);
  c_freeze_write: cover property (@(posedge clk) disable iff (rst)
    !clk_en && reg_wr);
  c_unmapped_hit: cover property (@(posedge clk) disable iff (rst)
    reg_wr && !wr_data_hit && !wr_cfg_hit);
endmodule // sbd_dio_port
`default_nettype wire

// ===== sbd_pkg.sv
/*
  Constants for the sixteen channel digital I/O port: register offsets,
  field positions and reset values.
  Assumes a plain register port with byte offsets and 16-bit data.
*/
// Operation
// - Sixteen channels form two groups of eight, each group wholly input or wholly output.
// - The high direction bit rules channels 15..8 and the low bit channels 7..0; 1 means input.
// - The direction register at offset 2A is read/write with its bits at 4 and 0, the rest zero.
// - A write to offset 28 loads the 16-bit output value, bit 0 for channel 0.
// - A read of offset 28 returns the 16 channel levels, channel 0 in bit 0.
// - Channels set as output read back the level being driven.
`default_nettype none
package sbd_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam logic [7:0] OFS_DIO_DATA = 8'h28;
  localparam logic [7:0] OFS_DIO_CFG = 8'h2A;
  localparam int unsigned POS_HIGH_DIR = 4;
  localparam int unsigned POS_LOW_DIR = 0;
  localparam logic [15:0] RST_OUT_DATA = 16'h0000;
  // All inputs after reset so nothing is driven before software decides
  localparam logic RST_DIR = 1'b1;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
endpackage
`default_nettype wire

// ===== sbd_ext_lines.sv
/*
  Model of the external lines on the card connector.
  Assumes the bench sets the level the far side applies to undriven lines.
*/
`timescale 1ns/1ps
`default_nettype none
module sbd_ext_lines
(
  // Pin side of the port
  input wire logic [15:0] dio_out,
  input wire logic [15:0] dio_oe,
  // Far side level on lines the port leaves alone
  input wire logic [15:0] far_level,
  output logic [15:0] dio_in
);
  // Driven bits win, so an output byte reads back its own level
  assign dio_in = (dio_out & dio_oe) | (far_level & ~dio_oe);
endmodule // sbd_ext_lines
`default_nettype wire

// ===== sbd_dio_port_tb.sv
/*
  Self-checking bench for the digital I/O port.
  Assumes the port answers reads exactly one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) chk(a, b)
module sbd_dio_port_tb;
  import sbd_pkg::*;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, clk_en = 1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, far_level = 16'hc3c3;
  logic [15:0] reg_rdata, dio_in, dio_out, dio_oe, rd;
  int fail_count = 0, comparisons = 0;
  ////////////////////////////////////////////////////////////////
  always #2 clk = ~clk;
  sbd_dio_port sbd_dio_port_i (.clk(clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe));
  sbd_ext_lines sbd_ext_lines_i (.dio_out(dio_out), .dio_oe(dio_oe), .far_level(far_level),
    .dio_in(dio_in));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle bus strobes; read data sampled in the following cycle only
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic test_done();
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic test_inputs();
    far_level <= 16'ha55a;
    `CHK(dio_oe, 16'h0000);
    rdr(OFS_DIO_CFG);
    `CHK(rd, 16'h0011);
    rdr(OFS_DIO_DATA);
    `CHK(rd, 16'ha55a);
  endtask
  // Every direction code, with the latch written after the change
  task automatic test_modes();
    logic [15:0] oe;
    for (int m = 0; m < 4; m++)
    begin
      oe = {{8{~m[1]}}, {8{~m[0]}}};
      wr(OFS_DIO_CFG, {11'h7ff, m[1], 3'h7, m[0]});
      wr(OFS_DIO_DATA, 16'h1234 ^ m[15:0]);
      `CHK(dio_oe, oe);
      `CHK(dio_out, (16'h1234 ^ m[15:0]) & oe);
      rdr(OFS_DIO_CFG);
      `CHK(rd, {11'h000, m[1], 3'h0, m[0]});
      rdr(OFS_DIO_DATA);
      `CHK(rd, ((16'h1234 ^ m[15:0]) & oe) | (16'ha55a & ~oe));
    end
  endtask
  // Write then read with no gap, once on each register
  task automatic test_back_to_back();
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, OFS_DIO_CFG, 16'h0010};
    @(posedge clk) {reg_wr, reg_rd} <= 2'h1;
    @(posedge clk) {reg_rd, reg_wr, reg_addr, reg_wdata} <= {1'b0, 1'b1, OFS_DIO_DATA, 16'h9669};
    #1 rd = reg_rdata;
    `CHK(rd, 16'h0010);
    @(posedge clk) {reg_wr, reg_rd} <= 2'h1;
    @(posedge clk) reg_rd <= 1'b0;
    #1 rd = reg_rdata;
    `CHK(rd, 16'ha569);
  endtask
  // Both bytes driving, so a stray decode of the unmapped offset shows
  task automatic test_unmapped();
    wr(OFS_DIO_CFG, 16'h0000);
    wr(OFS_DIO_DATA, 16'h5aa5);
    wr(8'h2c, 16'hffff);
    rdr(8'h2c);
    `CHK(rd, 16'h0000);
    `CHK(dio_oe, 16'hffff);
    `CHK(dio_out, 16'h5aa5);
  endtask
  // A write under a low clock enable is not taken
  task automatic test_freeze();
    @(posedge clk) {clk_en, reg_wr, reg_addr, reg_wdata} <= {1'b0, 1'b1, OFS_DIO_DATA, 16'hffff};
    @(posedge clk) {clk_en, reg_wr} <= 2'h2;
    #1;
    `CHK(dio_out, 16'h5aa5);
  endtask
  // Mid-run reset drops both bytes back to input with a cleared latch
  task automatic test_reset();
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    #1;
    `CHK(dio_oe, 16'h0000);
    `CHK(dio_out, 16'h0000);
    rdr(OFS_DIO_CFG);
    `CHK(rd, 16'h0011);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    test_inputs();
    test_modes();
    test_back_to_back();
    test_unmapped();
    test_freeze();
    test_reset();
    test_done();
  end
endmodule // sbd_dio_port_tb
`default_nettype wire
